// ==== design/rqw_map.svh ====
// Operation
// - dma write issue means probes; dram location blocked until data moves
// - pio write issue moves cpu data into the to_io_data_queue
// - pio read counts as issued once its command goes to the bridge
// - peer write issue moves data from_io_data_queue into to_io_data_queue
// - pio and peer reads go to the bridges in arrival order
// - pio or peer read waits until earlier pio or peer writes issued
// - cpu memory accesses are never ordered against pio or peer operations
// - reads wait for older dma reads; peer reads complete after them
// - pio or peer read after a dma write waits until it completes
// - dma write landing while read data is pending finishes before delivery
// - dma write after read data arrived waits until that data is delivered
// - pio and peer writes may pass older pio and peer reads
// - pio and peer writes keep strict arrival order among themselves
// - dma read waits to issue behind writes; its data may pass them
// - write data after a dma read waits until that read data delivered
// - pio and peer writes stay ordered against dma writes both ways
// - cpu request waits on same address only from another cpu
// - addresses match when bits 26..12 and 7..6 are equal
// - cpu and dma requests to matching addresses are ordered both ways
// - victim writeback matching a dma write waits until that write is done
// - dma reads issue and deliver data strictly in arrival order
// - dma write data reaches memory before any other access there
// - dma probes issue in arrival order even for unequal addresses
`ifndef RQW_MAP_SVH
`define RQW_MAP_SVH

`define RQW_DEPTH       6
`define RQW_ADDR_W      35
`define RQW_SRC_W       2
`define RQW_KEY_HI_MSB  26
`define RQW_KEY_HI_LSB  12
`define RQW_KEY_LO_MSB  7
`define RQW_KEY_LO_LSB  6
`define RQW_KEY_W       17
`define RQW_MAX_DEPTH   16

`endif

// ==== design/rqw_pkg.sv ====
package rqw_pkg;

  // request classes
  typedef enum logic [2:0] {
    RQW_CPU_MEM = 3'h0,
    RQW_DMA_RD  = 3'h1,
    RQW_DMA_WR  = 3'h2,
    RQW_PIO_RD  = 3'h3,
    RQW_PIO_WR  = 3'h4,
    RQW_PEER_RD = 3'h5,
    RQW_PEER_WR = 3'h6
  } rqw_type_t;

  // entry life cycle
  typedef enum logic [3:0] {
    RQW_FREE   = 4'h1,
    RQW_WAIT   = 4'h2,
    RQW_READY  = 4'h4,
    RQW_ISSUED = 4'h8
  } rqw_state_t;

  // how long a younger entry holds behind an older one
  typedef enum logic [1:0] {
    RQW_NONE      = 2'h0,
    RQW_TIL_ISSUE = 2'h1,
    RQW_TIL_GONE  = 2'h2
  } rqw_hold_t;

endpackage : rqw_pkg

// ==== design/rqw_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface rqw_if #(
  parameter int DEPTH = 6,
  parameter int KW    = 17,
  parameter int SW    = 3
);
  logic [DEPTH-1:0] busy;
  logic [KW-1:0]    key [DEPTH];
  logic [KW-1:0]    new_key;
  logic [DEPTH-1:0] match;
  logic             found;
  logic [SW-1:0]    slot;

  modport top   (output busy, output key, output new_key,
                 input match, input found, input slot);
  modport alloc (input busy, output found, output slot);
  modport cmp   (input key, input new_key, output match);
endinterface : rqw_if

`default_nettype wire

// ==== design/rqw_alloc.sv ====
`timescale 1ns/100ps
`default_nettype none

module rqw_alloc #(
  parameter int DEPTH = 6,
  parameter int SW    = 3
) (
  rqw_if.alloc a
);
  // lowest free slot wins
  always_comb
  begin
    a.found = 1'b0;
    a.slot  = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (!a.busy[i])
      begin
        a.found = 1'b1;
        a.slot  = SW'(i);
      end
    end
  end
endmodule : rqw_alloc

`default_nettype wire

// ==== design/rqw_match.sv ====
`timescale 1ns/100ps
`default_nettype none

module rqw_match #(
  parameter int DEPTH = 6
) (
  rqw_if.cmp c
);
  // exact compare of stored keys with the arriving key
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_cmp
    assign c.match[g] = (c.key[g] == c.new_key);
  end
endmodule : rqw_match

`default_nettype wire

// ==== design/rqw_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rqw_map.svh"

module rqw_top #(
  parameter int DEPTH  = `RQW_DEPTH,
  parameter int ADDR_W = `RQW_ADDR_W,
  localparam int SW    = $clog2(DEPTH),
  localparam int KW    = `RQW_KEY_W,
  localparam int SRCW  = `RQW_SRC_W
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              REQ_VALID,
  input  wire logic [2:0]        REQ_TYPE,
  input  wire logic [SRCW-1:0]   REQ_SRC,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  output logic                   REQ_ACCEPT,
  output logic [SW-1:0]          REQ_SLOT,
  input  wire logic              ISSUE_VALID,
  input  wire logic [SW-1:0]     ISSUE_SLOT,
  input  wire logic              RDATA_VALID,
  input  wire logic [SW-1:0]     RDATA_SLOT,
  input  wire logic              DONE_VALID,
  input  wire logic [SW-1:0]     DONE_SLOT,
  output logic [DEPTH-1:0]       BUSY_MASK,
  output logic [DEPTH-1:0]       READY_MASK,
  output logic [DEPTH-1:0]       DATA_OK_MASK,
  output logic [DEPTH-1:0]       DELIVER_OK_MASK
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (DEPTH < 2 || DEPTH > `RQW_MAX_DEPTH)
  begin : g_bad_depth
    $error("rqw_top: DEPTH out of range");
  end
  if (ADDR_W <= `RQW_KEY_HI_MSB)
  begin : g_bad_addr
    $error("rqw_top: ADDR_W too narrow for the match key");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rqw_pkg::rqw_state_t st;
    rqw_pkg::rqw_type_t  typ;
    logic [SRCW-1:0]     src;
    logic [KW-1:0]       key;
    logic                arr;
    logic [DEPTH-1:0]    older;
    logic [DEPTH-1:0]    amat;
    logic [DEPTH-1:0]    flush;
  } rqw_ent_t;

  typedef struct packed {
    rqw_ent_t [DEPTH-1:0] ent;
  } rqw_regs_t;

  localparam rqw_ent_t ENT_RST = '{st: rqw_pkg::RQW_FREE,
                                   typ: rqw_pkg::RQW_CPU_MEM,
                                   default: '0};

  rqw_regs_t        st_q;
  rqw_regs_t        st_d;
  logic [DEPTH-1:0] wait_v;
  logic [DEPTH-1:0] dhold;
  logic [DEPTH-1:0] flushb;
  logic [DEPTH-1:0] busy;
  logic             alloc_fire;
  rqw_pkg::rqw_type_t req_typ;

  rqw_if #(.DEPTH(DEPTH), .KW(KW), .SW(SW)) q_if ();

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_rd(input rqw_pkg::rqw_type_t t);
    return (t == rqw_pkg::RQW_PIO_RD) || (t == rqw_pkg::RQW_PEER_RD);
  endfunction : is_rd

  function automatic logic is_wr(input rqw_pkg::rqw_type_t t);
    return (t == rqw_pkg::RQW_PIO_WR) || (t == rqw_pkg::RQW_PEER_WR);
  endfunction : is_wr

  function automatic logic is_dma(input rqw_pkg::rqw_type_t t);
    return (t == rqw_pkg::RQW_DMA_RD) || (t == rqw_pkg::RQW_DMA_WR);
  endfunction : is_dma

  // issue-time hold of younger ti behind older tj
  function automatic rqw_pkg::rqw_hold_t hold_of(
    input rqw_pkg::rqw_type_t ti,
    input rqw_pkg::rqw_type_t tj,
    input logic               mat,
    input logic               same_src,
    input logic               arr_j
  );
    rqw_pkg::rqw_hold_t h;
    h = rqw_pkg::RQW_NONE;
    if (is_rd(ti))
    begin
      if (is_rd(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (is_wr(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (tj == rqw_pkg::RQW_DMA_RD)
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (tj == rqw_pkg::RQW_DMA_WR)
        h = rqw_pkg::RQW_TIL_GONE;
      else
        h = rqw_pkg::RQW_NONE;
    end
    else if (is_wr(ti))
    begin
      if (is_wr(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (is_dma(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else
        h = rqw_pkg::RQW_NONE;
    end
    else if (ti == rqw_pkg::RQW_CPU_MEM)
    begin
      if (tj == rqw_pkg::RQW_CPU_MEM && mat && !same_src)
        h = rqw_pkg::RQW_TIL_GONE;
      else if (is_dma(tj) && mat)
        h = rqw_pkg::RQW_TIL_GONE;
      else
        h = rqw_pkg::RQW_NONE;
    end
    else if (ti == rqw_pkg::RQW_DMA_RD)
    begin
      if (is_wr(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (tj == rqw_pkg::RQW_CPU_MEM && mat)
        h = rqw_pkg::RQW_TIL_GONE;
      else if (is_dma(tj))
        h = mat ? rqw_pkg::RQW_TIL_GONE
                : rqw_pkg::RQW_TIL_ISSUE;
      else
        h = rqw_pkg::RQW_NONE;
    end
    else if (ti == rqw_pkg::RQW_DMA_WR)
    begin
      if (is_rd(tj))
        h = arr_j ? rqw_pkg::RQW_TIL_GONE : rqw_pkg::RQW_NONE;
      else if (is_wr(tj))
        h = rqw_pkg::RQW_TIL_ISSUE;
      else if (tj == rqw_pkg::RQW_CPU_MEM && mat)
        h = rqw_pkg::RQW_TIL_GONE;
      else if (is_dma(tj))
        h = mat ? rqw_pkg::RQW_TIL_GONE
                : rqw_pkg::RQW_TIL_ISSUE;
      else
        h = rqw_pkg::RQW_NONE;
    end
    return h;
  endfunction : hold_of

  // data of ti may not move while an older tj is still live
  function automatic logic data_hold(
    input rqw_pkg::rqw_type_t ti,
    input rqw_pkg::rqw_type_t tj
  );
    logic d;
    d = 1'b0;
    if (is_wr(ti))
      d = is_wr(tj) || is_dma(tj);
    else if (ti == rqw_pkg::RQW_DMA_RD)
      d = (tj == rqw_pkg::RQW_DMA_RD);
    else if (ti == rqw_pkg::RQW_DMA_WR)
      d = is_wr(tj) || (tj == rqw_pkg::RQW_DMA_WR);
    else if (ti == rqw_pkg::RQW_PEER_RD)
      d = (tj == rqw_pkg::RQW_DMA_RD);
    return d;
  endfunction : data_hold

  ////////////////////////////////////////////////////////////////////////////
  // slot allocation and address compare

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      busy[i]     = (st_q.ent[i].st != rqw_pkg::RQW_FREE);
      q_if.key[i] = st_q.ent[i].key;
    end
  end

  assign q_if.busy    = busy;
  assign q_if.new_key = {REQ_ADDR[`RQW_KEY_HI_MSB:`RQW_KEY_HI_LSB],
                         REQ_ADDR[`RQW_KEY_LO_MSB:`RQW_KEY_LO_LSB]};

  rqw_alloc #(.DEPTH(DEPTH), .SW(SW)) u_alloc (.a(q_if.alloc));
  rqw_match #(.DEPTH(DEPTH)) u_match (.c(q_if.cmp));

  assign req_typ    = rqw_pkg::rqw_type_t'(REQ_TYPE);
  assign REQ_ACCEPT = q_if.found;
  assign REQ_SLOT   = q_if.slot;
  assign alloc_fire = REQ_VALID && q_if.found;

  ////////////////////////////////////////////////////////////////////////////
  // wait evaluation and next state

  always_comb
  begin
    rqw_pkg::rqw_hold_t h;
    h      = rqw_pkg::RQW_NONE;
    st_d   = st_q;
    wait_v = '0;
    dhold  = '0;
    flushb = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      for (int j = 0; j < DEPTH; j++)
      begin
        if (st_q.ent[i].older[j] && busy[j])
        begin
          h = hold_of(st_q.ent[i].typ, st_q.ent[j].typ,
                      st_q.ent[i].amat[j],
                      st_q.ent[i].src == st_q.ent[j].src,
                      st_q.ent[j].arr && !st_q.ent[i].flush[j]);
          if (h == rqw_pkg::RQW_TIL_GONE ||
              (h == rqw_pkg::RQW_TIL_ISSUE &&
               st_q.ent[j].st != rqw_pkg::RQW_ISSUED))
            wait_v[i] = 1'b1;
          if (data_hold(st_q.ent[i].typ, st_q.ent[j].typ))
            dhold[i] = 1'b1;
        end
        if (st_q.ent[j].flush[i] && busy[j])
          flushb[i] = 1'b1;
      end
    end

    for (int i = 0; i < DEPTH; i++)
    begin
      case (st_q.ent[i].st)
        rqw_pkg::RQW_FREE:
        begin
          if (alloc_fire && q_if.slot == SW'(i))
          begin
            st_d.ent[i].st    = rqw_pkg::RQW_WAIT;
            st_d.ent[i].typ   = req_typ;
            st_d.ent[i].src   = REQ_SRC;
            st_d.ent[i].key   = q_if.new_key;
            st_d.ent[i].arr   = 1'b0;
            st_d.ent[i].older = busy;
            st_d.ent[i].amat  = q_if.match & busy;
            st_d.ent[i].flush = '0;
            if (req_typ == rqw_pkg::RQW_DMA_WR)
            begin
              for (int k = 0; k < DEPTH; k++)
                st_d.ent[i].flush[k] = is_rd(st_q.ent[k].typ) &&
                  st_q.ent[k].st == rqw_pkg::RQW_ISSUED &&
                  !st_q.ent[k].arr;
            end
          end
        end
        rqw_pkg::RQW_WAIT:
        begin
          if (!wait_v[i])
            st_d.ent[i].st = rqw_pkg::RQW_READY;
        end
        rqw_pkg::RQW_READY:
        begin
          // issue means probes, command sent or data queued, by class
          if (ISSUE_VALID && ISSUE_SLOT == SW'(i))
            st_d.ent[i].st = rqw_pkg::RQW_ISSUED;
        end
        rqw_pkg::RQW_ISSUED:
        begin
          if (RDATA_VALID && RDATA_SLOT == SW'(i) &&
              is_rd(st_q.ent[i].typ))
            st_d.ent[i].arr = 1'b1;
          // entry stays live, blocking its location, until data moved
          if (DONE_VALID && DONE_SLOT == SW'(i))
            st_d.ent[i] = ENT_RST;
        end
        default:
          st_d.ent[i] = ENT_RST;
      endcase
    end

    // a freed slot is no longer older than anyone
    if (DONE_VALID && st_q.ent[DONE_SLOT].st == rqw_pkg::RQW_ISSUED)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        st_d.ent[i].older[DONE_SLOT] = 1'b0;
        st_d.ent[i].amat[DONE_SLOT]  = 1'b0;
        st_d.ent[i].flush[DONE_SLOT] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < DEPTH; i++)
        st_q.ent[i] <= ENT_RST;
    end
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      BUSY_MASK[i]       = busy[i];
      READY_MASK[i]      = (st_q.ent[i].st == rqw_pkg::RQW_READY);
      DATA_OK_MASK[i]    = (st_q.ent[i].st == rqw_pkg::RQW_ISSUED) &&
                           (is_wr(st_q.ent[i].typ) ||
                            is_dma(st_q.ent[i].typ)) &&
                           !dhold[i];
      DELIVER_OK_MASK[i] = (st_q.ent[i].st == rqw_pkg::RQW_ISSUED) &&
                           is_rd(st_q.ent[i].typ) &&
                           st_q.ent[i].arr && !flushb[i] &&
                           !dhold[i];
    end
  end

endmodule : rqw_top

`default_nettype wire

// ==== verif/rqw_chk_sva.sv ====
`timescale 1ns/100ps
`default_nettype none

module rqw_chk #(
  parameter int DEPTH = 6,
  parameter int SW    = 3
) (
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic             REQ_VALID,
  input wire logic             REQ_ACCEPT,
  input wire logic [SW-1:0]    REQ_SLOT,
  input wire logic             ISSUE_VALID,
  input wire logic [SW-1:0]    ISSUE_SLOT,
  input wire logic             DONE_VALID,
  input wire logic [SW-1:0]    DONE_SLOT,
  input wire logic [DEPTH-1:0] BUSY_MASK,
  input wire logic [DEPTH-1:0] READY_MASK,
  input wire logic [DEPTH-1:0] DATA_OK_MASK,
  input wire logic [DEPTH-1:0] DELIVER_OK_MASK
);
  logic [DEPTH-1:0] iss_q;
  logic [DEPTH-1:0] iss_d;

  // slots taken by the arbiter and not yet freed
  always_comb
  begin
    iss_d = iss_q;
    if (ISSUE_VALID && READY_MASK[ISSUE_SLOT])
      iss_d[ISSUE_SLOT] = 1'b1;
    if (DONE_VALID && iss_q[DONE_SLOT])
      iss_d[DONE_SLOT] = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      iss_q <= '0;
    else
      iss_q <= iss_d;
  end

  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  busy_on_take_a: assert property (REQ_VALID && REQ_ACCEPT |=>
    BUSY_MASK[$past(REQ_SLOT)]) else $error("slot not busy after take");
  ready_late_a: assert property (REQ_VALID && REQ_ACCEPT |=>
    !READY_MASK[$past(REQ_SLOT)]) else $error("ready too early");
  accept_free_a: assert property (REQ_ACCEPT == !(&BUSY_MASK))
    else $error("accept disagrees with busy");
  slot_free_a: assert property (REQ_ACCEPT |-> !BUSY_MASK[REQ_SLOT])
    else $error("offered slot is busy");
  ready_busy_a: assert property ((READY_MASK & ~BUSY_MASK) == '0)
    else $error("ready slot not busy");
  issue_clear_a: assert property (ISSUE_VALID
    && READY_MASK[ISSUE_SLOT]
    |=> !READY_MASK[$past(ISSUE_SLOT)] && BUSY_MASK[$past(ISSUE_SLOT)])
    else $error("issue did not leave ready");
  done_free_a: assert property (DONE_VALID && iss_q[DONE_SLOT] |=>
    !BUSY_MASK[$past(DONE_SLOT)]) else $error("done did not free");
  data_ok_a: assert property ((DATA_OK_MASK & ~iss_q) == '0)
    else $error("data move before issue");
  deliver_ok_a: assert property (!(DELIVER_OK_MASK & ~iss_q))
    else $error("delivery before issue");
  refuse_hold_a: assert property (REQ_VALID && !REQ_ACCEPT
    && !DONE_VALID |=> BUSY_MASK == $past(BUSY_MASK))
    else $error("refused request stored");

  cover property (REQ_VALID && !REQ_ACCEPT);
  cover property ($rose(DELIVER_OK_MASK != '0));
  cover property ($rose(DATA_OK_MASK != '0));
endmodule : rqw_chk

bind rqw_top rqw_chk #(.DEPTH(DEPTH), .SW(SW)) u_chk (
  .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_ACCEPT(REQ_ACCEPT),
  .REQ_SLOT(REQ_SLOT), .ISSUE_VALID(ISSUE_VALID), .ISSUE_SLOT(ISSUE_SLOT),
  .DONE_VALID(DONE_VALID), .DONE_SLOT(DONE_SLOT), .BUSY_MASK(BUSY_MASK),
  .READY_MASK(READY_MASK), .DATA_OK_MASK(DATA_OK_MASK),
  .DELIVER_OK_MASK(DELIVER_OK_MASK)
);

`default_nettype wire

// ==== verif/rqw_far.sv ====
`timescale 1ns/100ps
`default_nettype none

module rqw_far (
  input  wire logic       clk,
  input  wire logic [5:0] ready,
  input  wire logic [5:0] data_ok,
  input  wire logic [5:0] deliver_ok,
  output logic            issue_v,
  output logic [2:0]      issue_s,
  output logic            rdata_v,
  output logic [2:0]      rdata_s,
  output logic            done_v,
  output logic [2:0]      done_s
);
  initial
  begin
    issue_v = 1'b0;
    issue_s = 3'h0;
    rdata_v = 1'b0;
    rdata_s = 3'h0;
    done_v = 1'b0;
    done_s = 3'h0;
  end

  //////////////////////////////////////////////////////////////
  task automatic issue(input logic [2:0] s);
    int n;
    n = 0;
    while (!ready[s] && n < 16)
    begin
      @(negedge clk);
      n++;
    end
    issue_v <= 1'b1;
    issue_s <= s;
    @(negedge clk);
    issue_v <= 1'b0;
    issue_s <= ~s;
  endtask : issue

  task automatic rdata(input logic [2:0] s);
    rdata_v <= 1'b1;
    rdata_s <= s;
    @(negedge clk);
    rdata_v <= 1'b0;
    rdata_s <= ~s;
  endtask : rdata

  task automatic finish(input logic [2:0] s, input bit rd);
    int n;
    n = 0;
    repeat (1 + $urandom_range(3)) @(negedge clk);
    if (rd)
      rdata(s);
    while (!(data_ok[s] || deliver_ok[s]) && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    done_v <= 1'b1;
    done_s <= s;
    @(negedge clk);
    done_v <= 1'b0;
    done_s <= ~s;
  endtask : finish

  task automatic retire(input logic [2:0] s, input bit rd);
    issue(s);
    finish(s, rd);
  endtask : retire
endmodule : rqw_far

`default_nettype wire

// ==== verif/request_ordering_wait_logic_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module request_ordering_wait_logic_bench;
  localparam logic [34:0] KEEP = 35'h0_07FF_F0C0;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        REQ_VALID = 1'b0;
  logic [2:0]  REQ_TYPE = 3'h0;
  logic [1:0]  REQ_SRC = 2'h0;
  logic [34:0] REQ_ADDR = 35'h0;
  logic        REQ_ACCEPT, ISSUE_VALID, RDATA_VALID, DONE_VALID;
  logic [2:0]  REQ_SLOT, ISSUE_SLOT, RDATA_SLOT, DONE_SLOT;
  logic [5:0]  BUSY_MASK, READY_MASK, DATA_OK_MASK, DELIVER_OK_MASK;
  logic [5:0]  m_busy = 6'h00;
  logic [2:0]  sa, sb;
  int          q[$];
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;

  rqw_top u_dut (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_TYPE(REQ_TYPE), .REQ_SRC(REQ_SRC), .REQ_ADDR(REQ_ADDR),
    .REQ_ACCEPT(REQ_ACCEPT), .REQ_SLOT(REQ_SLOT), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_SLOT(ISSUE_SLOT), .RDATA_VALID(RDATA_VALID),
    .RDATA_SLOT(RDATA_SLOT), .DONE_VALID(DONE_VALID), .DONE_SLOT(DONE_SLOT),
    .BUSY_MASK(BUSY_MASK), .READY_MASK(READY_MASK),
    .DATA_OK_MASK(DATA_OK_MASK), .DELIVER_OK_MASK(DELIVER_OK_MASK));

  rqw_far u_far (.clk(CLK), .ready(READY_MASK), .data_ok(DATA_OK_MASK),
    .deliver_ok(DELIVER_OK_MASK), .issue_v(ISSUE_VALID),
    .issue_s(ISSUE_SLOT), .rdata_v(RDATA_VALID), .rdata_s(RDATA_SLOT),
    .done_v(DONE_VALID), .done_s(DONE_SLOT));

  always #20 CLK = ~CLK;

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic cmp_mask(input string n, input logic [5:0] e,
                          input logic [5:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_mask

  task automatic alloc(input logic [2:0] t, input logic [1:0] s,
                       input logic [34:0] a, output logic [2:0] k);
    int e;
    e = 0;
    while (m_busy[e])
      e++;
    @(negedge CLK);
    REQ_VALID <= 1'b1;
    REQ_TYPE <= t;
    REQ_SRC <= s;
    REQ_ADDR <= a;
    #5;
    cmp_mask("slot", 6'(e), {3'h0, REQ_SLOT});
    k = REQ_SLOT;
    @(negedge CLK);
    REQ_VALID <= 1'b0;
    m_busy[e] = 1'b1;
    cmp_mask("busy", m_busy, BUSY_MASK);
  endtask : alloc

  // w: 0 none, 1 until issued, 2 until done, 3 waits at least until issued
  task automatic pair(input int o, input int y, input bit m, input bit ss,
                      input int w);
    logic [34:0] a, b;
    logic [2:0]  so, sy;
    a = 35'({$urandom, $urandom});
    b = m ? ((a & KEEP) | (35'({$urandom, $urandom}) & ~KEEP)) : a ^ 35'h1000;
    alloc(3'(o), 2'h0, a, so);
    alloc(3'(y), ss ? 2'h0 : 2'h1, b, sy);
    repeat (3) @(negedge CLK);
    cmp_mask("ready", {4'h0, w == 0, 1'b1},
             {4'h0, READY_MASK[sy], READY_MASK[so]});
    u_far.issue(so);
    repeat (3) @(negedge CLK);
    if (w < 3)
      cmp_mask("ready", {5'h00, w < 2}, {5'h00, READY_MASK[sy]});
    u_far.finish(so, o == 3 || o == 5);
    m_busy[so] = 1'b0;
    repeat (3) @(negedge CLK);
    cmp_mask("ready", 6'h01, {5'h00, READY_MASK[sy]});
    u_far.retire(sy, y == 3 || y == 5);
    m_busy[sy] = 1'b0;
    @(negedge CLK);
    cmp_mask("busy", m_busy, BUSY_MASK);
  endtask : pair

  //////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h630A));
    repeat (8) @(negedge CLK);
    RST <= 1'b0;
    pair(0, 0, 1, 0, 3);
    pair(0, 0, 1, 1, 0);
    pair(0, 0, 0, 0, 0);
    pair(1, 0, 1, 0, 3);
    pair(0, 2, 1, 0, 3);
    pair(2, 0, 1, 0, 3);
    pair(4, 0, 0, 0, 0);
    pair(0, 3, 0, 0, 0);
    pair(3, 5, 0, 0, 1);
    pair(4, 3, 0, 0, 1);
    pair(6, 5, 0, 0, 1);
    pair(1, 3, 0, 0, 1);
    pair(5, 1, 0, 0, 0);
    pair(2, 5, 0, 0, 2);
    pair(3, 4, 0, 0, 0);
    pair(4, 6, 0, 0, 1);
    pair(4, 1, 0, 0, 1);
    pair(1, 1, 0, 0, 1);
    pair(2, 1, 0, 0, 1);
    pair(1, 2, 0, 0, 1);
    pair(3, 2, 0, 0, 0);
    alloc(3'h3, 2'h0, 35'h0, sa);
    u_far.issue(sa);
    alloc(3'h2, 2'h1, 35'h1000, sb);
    u_far.issue(sb);
    u_far.rdata(sa);
    cmp_mask("deliver", 6'h00, {5'h00, DELIVER_OK_MASK[sa]});
    u_far.finish(sb, 1'b0);
    m_busy[sb] = 1'b0;
    cmp_mask("deliver", 6'h01, {5'h00, DELIVER_OK_MASK[sa]});
    u_far.finish(sa, 1'b0);
    m_busy[sa] = 1'b0;
    alloc(3'h3, 2'h0, 35'h0, sa);
    u_far.issue(sa);
    u_far.rdata(sa);
    alloc(3'h2, 2'h1, 35'h2000, sb);
    repeat (3) @(negedge CLK);
    cmp_mask("ready", 6'h00, {5'h00, READY_MASK[sb]});
    u_far.finish(sa, 1'b0);
    m_busy[sa] = 1'b0;
    repeat (3) @(negedge CLK);
    cmp_mask("ready", 6'h01, {5'h00, READY_MASK[sb]});
    u_far.retire(sb, 1'b0);
    m_busy[sb] = 1'b0;
    @(negedge CLK);
    cmp_mask("busy", m_busy, BUSY_MASK);
    for (int i = 0; i < 6; i++)
    begin
      alloc(3'h0, 2'h0, 35'(i) << 12, sa);
      q.push_back(int'(sa));
    end
    cmp_mask("accept", 6'h00, {5'h00, REQ_ACCEPT});
    @(negedge CLK);
    REQ_VALID <= 1'b1;
    @(negedge CLK);
    REQ_VALID <= 1'b0;
    @(negedge CLK);
    cmp_mask("busy", 6'h3F, BUSY_MASK);
    while (q.size() > 0)
      u_far.retire(3'(q.pop_front()), 1'b0);
    @(negedge CLK);
    cmp_mask("busy", 6'h00, BUSY_MASK);
    finish_test();
  end
endmodule : request_ordering_wait_logic_bench

`default_nettype wire
